/* feedback_sensor_model.sv */
// Partner model: process feedback sensor with one cycle of lag.
// Assumes the bench sets the process level synchronously to clock.
`timescale 1ns/1ps
module feedback_sensor_model (
	input wire clock,
	input wire reset,
	input wire signed [15:0] process_level,
	output reg signed [15:0] feedback_ff
);
	// Registered, so the device never sees a level change in the same edge
	always @(posedge clock or posedge reset) begin
		if (reset)
			feedback_ff <= 16'sh0000;
		else
			feedback_ff <= process_level;
	end
endmodule // feedback_sensor_model

/* pid_trim_consts.vh */
// Constants for the process PID speed trim block.
// Assumes a 100 MHz clock and a plain register port with 32-bit data.
`ifndef PID_TRIM_CONSTS_VH
`define PID_TRIM_CONSTS_VH
// Register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_SETPOINT_CMD 8'h04
`define REG_ADJ_LIMIT 8'h08
`define REG_TOLERANCE 8'h0c
`define REG_PROP_GAIN 8'h10
`define REG_INTG_GAIN 8'h14
`define REG_INTG_LIMIT 8'h18
`define REG_DIFF_GAIN 8'h1c
`define REG_ADJ_BAND 8'h20
`define REG_SLEEP_BAND 8'h24
`define REG_FILTER 8'h28
`define REG_OFFSET 8'h2c
`define REG_OUT_GAIN 8'h30
`define REG_STATUS 8'h34
`define REG_CORRECTION 8'h38
`define REG_ERROR 8'h3c
// Control fields
`define CTRL_TYPE_LSB 0
`define CTRL_SRC_BIT 2
`define CTRL_PROFILE_BIT 3
`define TYPE_NONE 2'h0
`define TYPE_FORWARD 2'h1
`define TYPE_REVERSE 2'h2
// Reset values
`define CTRL_RESET 32'h0000_0000
`define GAIN_RESET 16'h0100
// Timing
`define CLOCK_HZ 100000000
`define TICK_US 100
`define TICK_CYCLES (`TICK_US * (`CLOCK_HZ / 1000000))
`define SLEEP_S 5
`define SLEEP_TICKS (`SLEEP_S * (1000000 / `TICK_US))
`endif

/* process_pid_speed_trim.v */
// Process PID speed trim: error, PID terms, limit, filter, offset, gain.
// Assumes feedback and setpoint inputs are synchronous to clock; values are
// signed Q8.8 percent of range, gains Q8.8 unsigned.
// Summary of operation
// - Type none: PID off, feedforward passes
// - Forward acting: error is setpoint minus feedback
// - Reverse acting: error is feedback minus setpoint
// - Limit correction magnitude to adjust limit
// - Fixed source uses stored setpoint command
// - Setpoint command is percent of feedback range
// - In-range output when error within tolerance
// - Proportional term is gain times error
// - Integral accumulates gain times error
// - Clamp integrator to integrator limit
// - Differential term from error change
// - Profile adjust enable gates group selection
// - Group 1 inside band, group 2 outside
// - Sleep after five seconds inside band
// - Leave sleep when error leaves band
// - Zero sleep band disables sleep
// - Low-pass filter the PID output
// - Add offset to PID output
// - Multiply PID output by output gain
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "pid_trim_consts.vh"

module process_pid_speed_trim #(
	parameter TICK_CYCLES = `TICK_CYCLES,
	parameter SLEEP_TICKS = `SLEEP_TICKS
) (
	input wire clock,
	input wire reset,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata_ff,
	input wire signed [15:0] setpoint_in,
	input wire signed [15:0] feedback_in,
	input wire signed [15:0] feedforward_in,
	output reg signed [15:0] speed_cmd_ff,
	output reg in_range_ff,
	output reg accel_group2_ff,
	output reg sleep_ff,
	output reg tick_ff
);

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [3:0] ctrl_ff;
reg signed [15:0] sp_cmd_ff;
reg [15:0] adj_limit_ff, tol_ff, kp_ff, ki_ff, ilim_ff, kd_ff;
reg [15:0] band_ff, sleep_band_ff, out_gain_ff;
reg [3:0] filt_ff;
reg signed [15:0] offset_ff;

always @(posedge clock or posedge reset) begin
	if (reset) begin
		ctrl_ff <= 4'h0;
		sp_cmd_ff <= 16'h0000;
		adj_limit_ff <= 16'h6400;
		tol_ff <= 16'h0000;
		kp_ff <= `GAIN_RESET;
		ki_ff <= 16'h0000;
		ilim_ff <= 16'h6400;
		kd_ff <= 16'h0000;
		band_ff <= 16'h0000;
		sleep_band_ff <= 16'h0000;
		filt_ff <= 4'h0;
		offset_ff <= 16'h0000;
		out_gain_ff <= `GAIN_RESET;
	end else if (wr) begin
		case (addr)
		`REG_CTRL: ctrl_ff <= wdata[3:0];
		`REG_SETPOINT_CMD: sp_cmd_ff <= wdata[15:0];
		`REG_ADJ_LIMIT: adj_limit_ff <= wdata[15:0];
		`REG_TOLERANCE: tol_ff <= wdata[15:0];
		`REG_PROP_GAIN: kp_ff <= wdata[15:0];
		`REG_INTG_GAIN: ki_ff <= wdata[15:0];
		`REG_INTG_LIMIT: ilim_ff <= wdata[15:0];
		`REG_DIFF_GAIN: kd_ff <= wdata[15:0];
		`REG_ADJ_BAND: band_ff <= wdata[15:0];
		`REG_SLEEP_BAND: sleep_band_ff <= wdata[15:0];
		`REG_FILTER: filt_ff <= wdata[3:0];
		`REG_OFFSET: offset_ff <= wdata[15:0];
		`REG_OUT_GAIN: out_gain_ff <= wdata[15:0];
		default: ;
		endcase
	end
end

wire [1:0] ptype = ctrl_ff[`CTRL_TYPE_LSB +: 2];
wire pid_on = (ptype == `TYPE_FORWARD) || (ptype == `TYPE_REVERSE);

////////////////////////////////////////////////////////////////////////////////
// Update tick
reg [31:0] tick_cnt_ff;
wire tick = (tick_cnt_ff == TICK_CYCLES - 1);

always @(posedge clock or posedge reset) begin
	if (reset) begin
		tick_cnt_ff <= 32'h0;
		tick_ff <= 1'b0;
	end else begin
		tick_cnt_ff <= tick ? 32'h0 : tick_cnt_ff + 32'h1;
		tick_ff <= tick;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Error and its magnitude
// Setpoint command is already in percent of feedback range
wire signed [15:0] setpoint = ctrl_ff[`CTRL_SRC_BIT] ? sp_cmd_ff : setpoint_in;
wire signed [16:0] diff_fw = {setpoint[15], setpoint} - {feedback_in[15], feedback_in};
wire signed [16:0] diff_rv = {feedback_in[15], feedback_in} - {setpoint[15], setpoint};
wire signed [16:0] err_raw = (ptype == `TYPE_REVERSE) ? diff_rv : diff_fw;
// Saturate to 16 bits so a full-scale swing cannot wrap
wire signed [15:0] err_now = (err_raw > 17'sd32767) ? 16'sh7fff :
	(err_raw < -17'sd32767) ? 16'sh8001 : err_raw[15:0];

reg signed [15:0] err_ff, prev_err_ff;
wire [15:0] err_mag = err_ff[15] ? (~err_ff + 16'h1) : err_ff;

////////////////////////////////////////////////////////////////////////////////
// PID terms
reg signed [31:0] integ_ff;
wire signed [31:0] p_term = err_now * $signed({1'b0, kp_ff});
wire signed [31:0] i_step = err_now * $signed({1'b0, ki_ff});
wire signed [16:0] d_err = {err_now[15], err_now} - {prev_err_ff[15], prev_err_ff};
wire signed [33:0] d_term = d_err * $signed({1'b0, kd_ff});
wire signed [31:0] ilim = {8'h00, ilim_ff, 8'h00};
wire signed [32:0] i_sum = {integ_ff[31], integ_ff} + {i_step[31], i_step};
wire signed [32:0] ilim_w = {ilim[31], ilim};
wire signed [31:0] i_next = (i_sum > ilim_w) ? ilim :
	(i_sum < -ilim_w) ? -ilim : i_sum[31:0];

// Sum in Q16.16 then back to Q8.8
wire signed [35:0] pid_sum = {{4{p_term[31]}}, p_term} + {{4{i_next[31]}}, i_next}
	+ {{2{d_term[33]}}, d_term};
wire signed [27:0] pid_q8 = pid_sum[35:8];
wire signed [27:0] lim = {12'h000, adj_limit_ff};
wire signed [15:0] pid_lim = (pid_q8 > lim) ? lim[15:0] :
	(pid_q8 < -lim) ? -lim[15:0] : pid_q8[15:0];

////////////////////////////////////////////////////////////////////////////////
// Filter, offset and gain
reg signed [31:0] filt_acc_ff;
wire signed [15:0] filt_out = filt_acc_ff[31:16];
wire signed [31:0] filt_in = {pid_lim, 16'h0000};
wire signed [31:0] filt_step = (filt_in - filt_acc_ff) >>> filt_ff;
wire signed [16:0] with_off = {filt_out[15], filt_out} + {offset_ff[15], offset_ff};
wire signed [33:0] scaled = with_off * $signed({1'b0, out_gain_ff});
wire signed [25:0] trim_w = scaled[33:8];
wire signed [15:0] trim = (trim_w > 26'sd32767) ? 16'sh7fff :
	(trim_w < -26'sd32767) ? 16'sh8001 : trim_w[15:0];
wire signed [16:0] cmd_sum = {feedforward_in[15], feedforward_in} + {trim[15], trim};
wire signed [15:0] cmd_sat = (cmd_sum > 17'sd32767) ? 16'sh7fff :
	(cmd_sum < -17'sd32767) ? 16'sh8001 : cmd_sum[15:0];

////////////////////////////////////////////////////////////////////////////////
// Sleep state machine
localparam S_RUN = 1'b0;
localparam S_SLEEP = 1'b1;
reg state_ff;
reg [31:0] dwell_ff;
wire in_sleep_band = (sleep_band_ff != 16'h0000) && (err_mag <= sleep_band_ff);

always @(posedge clock or posedge reset) begin
	if (reset) begin
		err_ff <= 16'h0000;
		prev_err_ff <= 16'h0000;
		integ_ff <= 32'h0;
		filt_acc_ff <= 32'h0;
		dwell_ff <= 32'h0;
		state_ff <= S_RUN;
	end else begin
		if (tick) begin
			err_ff <= err_now;
			prev_err_ff <= err_now;
			// Integrator holds while PID is off or asleep to avoid windup
			if (pid_on && state_ff == S_RUN)
				integ_ff <= i_next;
			filt_acc_ff <= pid_on ? filt_acc_ff + filt_step : 32'h0;
		end
		case (state_ff)
		S_RUN: begin
			if (!in_sleep_band || !pid_on)
				dwell_ff <= 32'h0;
			else if (tick) begin
				if (dwell_ff >= SLEEP_TICKS - 1) begin
					state_ff <= S_SLEEP;
					dwell_ff <= 32'h0;
				end else
					dwell_ff <= dwell_ff + 32'h1;
			end
		end
		S_SLEEP: begin
			if (!in_sleep_band || !pid_on)
				state_ff <= S_RUN;
		end
		default: state_ff <= S_RUN;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs
always @(posedge clock or posedge reset) begin
	if (reset) begin
		speed_cmd_ff <= 16'h0000;
		in_range_ff <= 1'b0;
		accel_group2_ff <= 1'b0;
		sleep_ff <= 1'b0;
	end else begin
		if (state_ff == S_SLEEP)
			speed_cmd_ff <= 16'h0000;
		else if (pid_on)
			speed_cmd_ff <= cmd_sat;
		else
			speed_cmd_ff <= feedforward_in;
		in_range_ff <= pid_on && (err_mag <= tol_ff);
		accel_group2_ff <= pid_on && ctrl_ff[`CTRL_PROFILE_BIT] && (err_mag > band_ff);
		sleep_ff <= (state_ff == S_SLEEP);
	end
end

// Read port; unmapped addresses read zero
always @(posedge clock or posedge reset) begin
	if (reset)
		rdata_ff <= 32'h0;
	else if (rd) begin
		case (addr)
		`REG_CTRL: rdata_ff <= {28'h0, ctrl_ff};
		`REG_SETPOINT_CMD: rdata_ff <= {16'h0, sp_cmd_ff};
		`REG_ADJ_LIMIT: rdata_ff <= {16'h0, adj_limit_ff};
		`REG_TOLERANCE: rdata_ff <= {16'h0, tol_ff};
		`REG_PROP_GAIN: rdata_ff <= {16'h0, kp_ff};
		`REG_INTG_GAIN: rdata_ff <= {16'h0, ki_ff};
		`REG_INTG_LIMIT: rdata_ff <= {16'h0, ilim_ff};
		`REG_DIFF_GAIN: rdata_ff <= {16'h0, kd_ff};
		`REG_ADJ_BAND: rdata_ff <= {16'h0, band_ff};
		`REG_SLEEP_BAND: rdata_ff <= {16'h0, sleep_band_ff};
		`REG_FILTER: rdata_ff <= {28'h0, filt_ff};
		`REG_OFFSET: rdata_ff <= {16'h0, offset_ff};
		`REG_OUT_GAIN: rdata_ff <= {16'h0, out_gain_ff};
		`REG_STATUS: rdata_ff <= {29'h0, sleep_ff, accel_group2_ff, in_range_ff};
		`REG_CORRECTION: rdata_ff <= {16'h0, filt_out};
		`REG_ERROR: rdata_ff <= {16'h0, err_ff};
		default: rdata_ff <= 32'h0;
		endcase
	end else
		rdata_ff <= 32'h0;
end

endmodule // process_pid_speed_trim

/* process_pid_speed_trim_props.sv */
// Checker: mode, sleep and tick relations of the PID speed trim.
// Assumes it is bound into the design and sees only its ports.
`timescale 1ns/1ps
`include "pid_trim_consts.vh"
module process_pid_speed_trim_props #(
	parameter TICK_CYCLES = 4,
	parameter SLEEP_TICKS = 5
) (
	input wire clock,
	input wire reset,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire signed [15:0] feedforward_in,
	input wire signed [15:0] speed_cmd_ff,
	input wire in_range_ff,
	input wire accel_group2_ff,
	input wire sleep_ff,
	input wire tick_ff
);
	reg [3:0] ctrl_ff;
	reg band_nz_ff;
	reg up_ff;
	reg seen_ff;
	reg [7:0] cyc_ff;
	reg [7:0] nt_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			ctrl_ff <= 4'h0;
			band_nz_ff <= 1'b0;
			up_ff <= 1'b0;
			seen_ff <= 1'b0;
			cyc_ff <= 8'h00;
			nt_ff <= 8'h00;
		end else begin
			if (wr && addr == `REG_CTRL)
				ctrl_ff <= wdata[3:0];
			if (wr && addr == `REG_SLEEP_BAND)
				band_nz_ff <= |wdata[15:0];
			up_ff <= 1'b1;
			seen_ff <= seen_ff | tick_ff;
			cyc_ff <= tick_ff ? 8'h00 : cyc_ff + 8'h01;
			// Saturating count: only a lower bound on the dwell is needed
			if ($fell(sleep_ff))
				nt_ff <= 8'h00;
			else if (tick_ff && nt_ff != 8'hff)
				nt_ff <= nt_ff + 8'h01;
		end
	end
	property p_none_pass;
		ctrl_ff[1:0] == 2'h0 && $past(ctrl_ff[1:0]) == 2'h0 && up_ff && !sleep_ff
			&& !$past(sleep_ff) |-> speed_cmd_ff == $past(feedforward_in);
	endproperty
	a_none_pass: assert property (p_none_pass) else $error("no feedforward pass");
	property p_range_off;
		(ctrl_ff[1:0] == 2'h0) [*8] |-> !in_range_ff;
	endproperty
	a_range_off: assert property (p_range_off) else $error("in range while off");
	property p_profile_off;
		(!ctrl_ff[3]) [*8] |-> !accel_group2_ff;
	endproperty
	a_profile_off: assert property (p_profile_off) else $error("group 2 while off");
	property p_sleep_zero;
		(!band_nz_ff) [*8] |-> !sleep_ff;
	endproperty
	a_sleep_zero: assert property (p_sleep_zero) else $error("sleep with zero band");
	property p_sleep_speed;
		sleep_ff && $past(sleep_ff) |-> speed_cmd_ff == 16'sh0000;
	endproperty
	a_sleep_speed: assert property (p_sleep_speed) else $error("drive while asleep");
	property p_sleep_dwell;
		$rose(sleep_ff) |-> band_nz_ff && nt_ff >= SLEEP_TICKS - 1;
	endproperty
	a_sleep_dwell: assert property (p_sleep_dwell) else $error("early sleep");
	property p_tick_pulse;
		tick_ff |=> !tick_ff;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
	property p_tick_period;
		tick_ff && seen_ff |-> cyc_ff == TICK_CYCLES - 1;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("tick period wrong");
endmodule // process_pid_speed_trim_props
bind process_pid_speed_trim process_pid_speed_trim_props #(
	.TICK_CYCLES(TICK_CYCLES),
	.SLEEP_TICKS(SLEEP_TICKS)
) i_process_pid_speed_trim_props (.clock, .reset, .addr, .wdata, .wr, .feedforward_in,
	.speed_cmd_ff, .in_range_ff, .accel_group2_ff, .sleep_ff, .tick_ff);

/* process_pid_speed_trim_tb.sv */
// Testbench for the PID speed trim: register port, modes, limits, sleep.
// Assumes short tick and sleep counts; feedback comes from the sensor model.
`timescale 1ns/1ps
`include "pid_trim_consts.vh"
module process_pid_speed_trim_tb;
	reg clock = 1'b0;
	reg reset = 1'b1;
	reg [7:0] addr = 8'h00;
	reg [31:0] wdata = 32'h0;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg signed [15:0] setpoint_in = 16'sh0;
	reg signed [15:0] level = 16'sh0;
	reg signed [15:0] feedforward_in = 16'sh0;
	wire signed [15:0] feedback_in;
	wire [31:0] rdata_ff;
	wire signed [15:0] speed_cmd_ff;
	wire in_range_ff, accel_group2_ff, sleep_ff, tick_ff;
	integer seed = 22523;
	integer error_cnt = 0;
	integer n_checks = 0;
	integer i;
	reg [31:0] v;
	reg [15:0] s, f;
	reg [1:0] t;
	process_pid_speed_trim #(.TICK_CYCLES(4), .SLEEP_TICKS(5)) i_process_pid_speed_trim (
		.clock, .reset, .addr, .wdata, .wr, .rd, .rdata_ff, .setpoint_in, .feedback_in,
		.feedforward_in, .speed_cmd_ff, .in_range_ff, .accel_group2_ff, .sleep_ff, .tick_ff);
	feedback_sensor_model i_feedback_sensor_model (.clock, .reset, .process_level(level),
		.feedback_ff(feedback_in));
	////////////////////////////////////////////////////////////
	initial forever #5 clock = ~clock;
	function [15:0] pe(input [1:0] k, input [15:0] a, input [15:0] b);
		pe = (k == `TYPE_REVERSE) ? b - a : a - b;
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wreg(input [7:0] a, input [31:0] d);
		begin
			@(posedge clock);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clock);
			wr <= 1'b0;
		end
	endtask
	task rreg(input [7:0] a);
		begin
			@(posedge clock);
			addr <= a;
			rd <= 1'b1;
			@(posedge clock);
			rd <= 1'b0;
			#1 v = rdata_ff;
		end
	endtask
	task drive(input [15:0] sp, input [15:0] lv);
		begin
			@(posedge clock);
			setpoint_in <= sp;
			level <= lv;
		end
	endtask
	// Tick period is fixed at 4 cycles; margin covers latching and output stage
	task ticks(input integer n);
		begin
			repeat (n * 4 + 3) @(posedge clock);
			#1;
		end
	endtask
	task give_verdict;
		begin
			$display("checks=%0d errors=%0d", n_checks, error_cnt);
			if (error_cnt == 0 && n_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		#100000;
		error_cnt = error_cnt + 1;
		give_verdict;
	end
	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		rreg(`REG_PROP_GAIN);
		chk(v, {16'h0, `GAIN_RESET});
		rreg(8'h40);
		chk(v, 32'h0);
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge clock);
			feedforward_in <= $random(seed);
			repeat (3) @(posedge clock);
			#1 chk(speed_cmd_ff, feedforward_in);
		end
		$display("test bus and bypass done");
		for (i = 0; i < 6; i = i + 1) begin
			s = $random(seed) & 16'h0fff;
			f = $random(seed) & 16'h0fff;
			t = (i % 2) ? `TYPE_REVERSE : `TYPE_FORWARD;
			wreg(`REG_CTRL, {29'h0, i > 3, t});
			wreg(`REG_SETPOINT_CMD, {16'h0, s});
			drive((i > 3) ? ~s : s, f);
			ticks(2);
			rreg(`REG_ERROR);
			chk(v[15:0], pe(t, s, f));
		end
		$display("test error sign done");
		// Forward, input setpoint, no feedforward so speed is the trim alone
		wreg(`REG_CTRL, {30'h0, `TYPE_FORWARD});
		feedforward_in <= 16'sh0;
		wreg(`REG_ADJ_LIMIT, 32'h200);
		drive(16'h1000, 16'h0);
		ticks(3);
		chk(speed_cmd_ff, 16'h0200);
		wreg(`REG_OFFSET, 32'h100);
		ticks(2);
		chk(speed_cmd_ff, 16'h0300);
		wreg(`REG_OUT_GAIN, 32'h200);
		ticks(2);
		chk(speed_cmd_ff, 16'h0600);
		// Integral only; clamp holds it at one percent despite a steady one percent error
		wreg(`REG_OUT_GAIN, {16'h0, `GAIN_RESET});
		wreg(`REG_OFFSET, 32'h0);
		wreg(`REG_PROP_GAIN, 32'h0);
		wreg(`REG_ADJ_LIMIT, 32'h6400);
		wreg(`REG_INTG_LIMIT, 32'h100);
		wreg(`REG_INTG_GAIN, 32'h100);
		drive(16'h0100, 16'h0);
		ticks(6);
		chk(speed_cmd_ff, 16'h0100);
		wreg(`REG_TOLERANCE, 32'h100);
		drive(16'h0080, 16'h0);
		ticks(2);
		chk(in_range_ff, 1'b1);
		drive(16'h0400, 16'h0);
		ticks(2);
		chk(in_range_ff, 1'b0);
		$display("test limit and range done");
		wreg(`REG_ADJ_BAND, 32'h100);
		for (i = 0; i < 4; i = i + 1) begin
			wreg(`REG_CTRL, {28'h0, i[1], 3'h1});
			drive(i[0] ? 16'h0400 : 16'h0010, 16'h0);
			ticks(2);
			chk(accel_group2_ff, i[1] & i[0]);
		end
		$display("test profile done");
		wreg(`REG_SLEEP_BAND, 32'h200);
		drive(16'h0, 16'h0);
		ticks(7);
		chk(sleep_ff, 1'b1);
		chk(speed_cmd_ff, 16'h0);
		drive(16'h0800, 16'h0);
		ticks(1);
		chk(sleep_ff, 1'b0);
		wreg(`REG_SLEEP_BAND, 32'h0);
		drive(16'h0, 16'h0);
		ticks(8);
		chk(sleep_ff, 1'b0);
		wreg(`REG_SLEEP_BAND, 32'h200);
		ticks(7);
		@(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		#1 chk(sleep_ff, 1'b0);
		@(posedge clock);
		reset <= 1'b0;
		$display("test sleep done");
		give_verdict;
	end
endmodule // process_pid_speed_trim_tb
